/* File: rtl/i2c_ctrl_defines.vh */
// Register offsets, field positions, reset values and the ninth-pulse count for the I2C control logic
`ifndef I2C_CTRL_DEFINES_VH
`define I2C_CTRL_DEFINES_VH

// ==========================================
// Register offsets
`define ADDR_BUS_CONTROL   4'h0
`define ADDR_BUS_STATUS    4'h1
`define ADDR_BUS_FLAG      4'h2
`define ADDR_CLOCK_SELECT  4'h3
`define ADDR_LINE_EVENT    4'h4

// ==========================================
// Control register fields
`define BIT_INTERFACE_ENABLE   7
`define BIT_LEAVE_COMM         6
`define BIT_WAIT_RELEASE       5
`define BIT_STOP_IRQ_ENABLE    4
`define BIT_WAIT_TIMING        3
`define BIT_ACK_ENABLE         2
`define BIT_START_TRIGGER      1
`define BIT_STOP_TRIGGER       0

// ==========================================
// Status register fields
`define BIT_MASTER_STATE       7
`define BIT_EXTENSION_CODE     6
`define BIT_ADDRESS_MATCH      5
`define BIT_TRANSMIT_DIR       4
`define BIT_ACK_DETECTED       3
`define BIT_START_DETECTED     2
`define BIT_STOP_DETECTED      1

// ==========================================
// Flag and clock select register fields
`define BIT_START_CLEAR        7
`define BIT_BUS_BUSY           6
`define BIT_CLOCK_LEVEL        5
`define BIT_DATA_LEVEL         4

// ==========================================
// Reset values
`define RST_BUS_CONTROL        8'h00
`define RST_BUS_STATUS         8'h00
`define RST_BYTE               8'h00

// ==========================================
// Clock-edge count of the ninth pulse
`define NINTH_CLOCK_COUNT      4'h9

`endif

/* File: rtl/i2c_line_sync.v */
// Two-stage synchroniser for the two bus lines
`timescale 1ns/1ps
module i2c_line_sync (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       rst_i,
   // Raw and synchronised lines
   input  wire [1:0] line_i,
   output wire [1:0] line_o
);
   reg [1:0] stage1_reg;
   reg [1:0] stage2_reg;

   // ==========================================
   // Synchroniser stages, idle lines high
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         stage1_reg <= 2'h3;
         stage2_reg <= 2'h3;
      end else begin
         stage1_reg <= line_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign line_o = stage2_reg;
endmodule // i2c_line_sync

/* File: rtl/i2c_cond_detect.v */
// Start/stop condition and clock edge detector on synchronised lines
`timescale 1ns/1ps
module i2c_cond_detect (
   // Clock and reset
   input  wire mclk_i,
   input  wire rst_i,
   // Synchronised lines and enable
   input  wire scl_i,
   input  wire sda_i,
   input  wire enable_i,
   // Events
   output wire start_o,
   output wire stop_o,
   output wire scl_rise_o,
   output wire scl_fall_o,
   output wire en_start_o
);
   reg scl_q_reg;
   reg sda_q_reg;
   reg en_q_reg;

   // ==========================================
   // Delayed copies for edge detection
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         en_q_reg  <= 1'b0;
      end else begin
         scl_q_reg <= scl_i;
         sda_q_reg <= sda_i;
         en_q_reg  <= enable_i;
      end
   end

   // Conditions are data edges while the clock is high
   assign start_o    = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
   assign stop_o     = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
   assign scl_rise_o = scl_i & ~scl_q_reg;
   assign scl_fall_o = ~scl_i & scl_q_reg;
   // Enable while clock high and data low counts as a start
   assign en_start_o = enable_i & ~en_q_reg & scl_i & ~sda_i;
endmodule // i2c_cond_detect

/* File: rtl/i2c_control_register_logic.v */
// I2C control register logic: enable, leave communication, wait release
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "i2c_ctrl_defines.vh"

// Functional notes
// - With the enable bit at 0 all internal operation except line event capture stops and the status register is reset.
// - Clearing the enable bit also resets start-clear, bus-busy, clock-level and data-level bits.
// - Writing 1 to leave-communication abandons the transfer, enters standby, releases both lines, self-clears.
// - Leaving communication clears start, stop, master, extension, match, direction, ack and start flags.
// - Standby lasts until a stop condition or an address match or extension code after a start.
// - Writing 1 to wait-release cancels the current wait and the bit self-clears once released.
// - Wait release at the ninth clock while transmitting releases data and clears transmit direction.
// - Leave-communication and wait-release have no effect while the enable bit is 0.
// - Enabling while clock is high and data is low detects a start condition at once.
module i2c_control_register_logic (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       rst_i,
   // Register port
   input  wire [3:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   output reg  [7:0] rdata_o,
   // Serial clock line
   input  wire       scl_i,
   output wire       scl_o,
   output wire       scl_oe_o,
   // Serial data line
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_o,
   // Status inputs from the protocol engine
   input  wire       addr_match_i,
   input  wire       ext_code_i,
   input  wire       ack_seen_i,
   input  wire       tx_dir_set_i,
   input  wire       master_set_i,
   input  wire       wait_hold_i,
   // Block state
   output wire       standby_o,
   output wire       waiting_o
);
   // ==========================================
   // State machine encodings
   localparam ST_IDLE    = 3'b001;
   localparam ST_ACTIVE  = 3'b010;
   localparam ST_STANDBY = 3'b100;

   // ==========================================
   // Declarations
   reg  [7:0] ctrl_reg;
   reg  [7:0] status_reg;
   reg        start_clear_reg;
   reg        bus_busy_reg;
   reg        clock_level_reg;
   reg        data_level_reg;
   reg  [2:0] state_reg;
   reg  [2:0] state_next;
   reg  [3:0] clk_cnt_reg;
   reg        wait_reg;
   reg        scl_hold_reg;
   reg        sda_drive_low_reg;
   reg  [1:0] event_reg;
   wire [1:0] lines_sync;
   wire       scl_s;
   wire       sda_s;
   wire       start_ev;
   wire       stop_ev;
   wire       scl_rise;
   wire       scl_fall;
   wire       en_start;
   wire       enabled;
   wire       ctrl_wr;
   wire       leave_go;
   wire       release_go;
   wire       ninth_wait;

   // Decode a register write at a given offset
   function wr_hit;
      input [3:0] a;
      input [3:0] target;
      input       strobe;
      begin
         wr_hit = strobe & (a == target);
      end
   endfunction

   // ==========================================
   // Line synchroniser and condition detector
   i2c_line_sync u_sync (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .line_i ({scl_i, sda_i}),
      .line_o (lines_sync)
   );

   assign scl_s = lines_sync[1];
   assign sda_s = lines_sync[0];

   i2c_cond_detect u_det (
      .mclk_i     (mclk_i),
      .rst_i      (rst_i),
      .scl_i      (scl_s),
      .sda_i      (sda_s),
      .enable_i   (enabled),
      .start_o    (start_ev),
      .stop_o     (stop_ev),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .en_start_o (en_start)
   );

   // ==========================================
   // Request decode
   assign enabled    = ctrl_reg[`BIT_INTERFACE_ENABLE];
   assign ctrl_wr    = wr_hit(addr_i, `ADDR_BUS_CONTROL, wr_i);
   assign leave_go   = enabled & ctrl_reg[`BIT_LEAVE_COMM];
   assign release_go = enabled & ctrl_reg[`BIT_WAIT_RELEASE] & wait_reg;
   assign ninth_wait = wait_reg & (clk_cnt_reg == `NINTH_CLOCK_COUNT);

   // ==========================================
   // Control register with self-clearing request bits
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= `RST_BUS_CONTROL;
      end else if (ctrl_wr) begin
         ctrl_reg <= wdata_i;
         if (!wdata_i[`BIT_INTERFACE_ENABLE]) begin
            ctrl_reg[`BIT_LEAVE_COMM]   <= 1'b0;
            ctrl_reg[`BIT_WAIT_RELEASE] <= 1'b0;
         end
      end else begin
         if (leave_go) begin
            ctrl_reg[`BIT_LEAVE_COMM]    <= 1'b0;
            ctrl_reg[`BIT_START_TRIGGER] <= 1'b0;
            ctrl_reg[`BIT_STOP_TRIGGER]  <= 1'b0;
         end
         if (release_go) begin
            ctrl_reg[`BIT_WAIT_RELEASE] <= 1'b0;
         end
         if (!enabled) begin
            ctrl_reg[`BIT_LEAVE_COMM]   <= 1'b0;
            ctrl_reg[`BIT_WAIT_RELEASE] <= 1'b0;
         end
      end
   end

   // ==========================================
   // Communication state machine
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (enabled) begin
               state_next = leave_go ? ST_STANDBY : ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!enabled) begin
               state_next = ST_IDLE;
            end else if (leave_go) begin
               state_next = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (!enabled) begin
               state_next = ST_IDLE;
            end else if (stop_ev || addr_match_i || ext_code_i) begin
               state_next = ST_ACTIVE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Clock pulse counter and wait tracking
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_cnt_reg <= 4'h0;
         wait_reg    <= 1'b0;
      end else if (!enabled || leave_go || start_ev) begin
         clk_cnt_reg <= 4'h0;
         wait_reg    <= 1'b0;
      end else begin
         if (scl_rise && state_reg == ST_ACTIVE) begin
            clk_cnt_reg <= (clk_cnt_reg == `NINTH_CLOCK_COUNT) ? 4'h1 : clk_cnt_reg + 4'h1;
         end
         if (release_go) begin
            wait_reg <= 1'b0;
         end else if (wait_hold_i && scl_fall && state_reg == ST_ACTIVE) begin
            wait_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // Status register
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         status_reg <= `RST_BUS_STATUS;
      end else if (!enabled) begin
         status_reg <= `RST_BUS_STATUS;
      end else if (leave_go) begin
         status_reg[`BIT_MASTER_STATE]   <= 1'b0;
         status_reg[`BIT_EXTENSION_CODE] <= 1'b0;
         status_reg[`BIT_ADDRESS_MATCH]  <= 1'b0;
         status_reg[`BIT_TRANSMIT_DIR]   <= 1'b0;
         status_reg[`BIT_ACK_DETECTED]   <= 1'b0;
         status_reg[`BIT_START_DETECTED] <= 1'b0;
      end else begin
         if (start_ev || en_start) begin
            status_reg[`BIT_START_DETECTED] <= 1'b1;
         end
         if (stop_ev) begin
            status_reg[`BIT_STOP_DETECTED] <= 1'b1;
         end
         if (state_reg == ST_ACTIVE) begin
            if (addr_match_i) begin
               status_reg[`BIT_ADDRESS_MATCH] <= 1'b1;
            end
            if (ext_code_i) begin
               status_reg[`BIT_EXTENSION_CODE] <= 1'b1;
            end
            if (ack_seen_i) begin
               status_reg[`BIT_ACK_DETECTED] <= 1'b1;
            end
            if (master_set_i) begin
               status_reg[`BIT_MASTER_STATE] <= 1'b1;
            end
         end
         if (release_go && ninth_wait && status_reg[`BIT_TRANSMIT_DIR]) begin
            status_reg[`BIT_TRANSMIT_DIR] <= 1'b0;
         end else if (tx_dir_set_i && state_reg == ST_ACTIVE) begin
            status_reg[`BIT_TRANSMIT_DIR] <= 1'b1;
         end
      end
   end

   // ==========================================
   // Flag and clock select bits
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         start_clear_reg <= 1'b0;
         bus_busy_reg    <= 1'b0;
         clock_level_reg <= 1'b0;
         data_level_reg  <= 1'b0;
      end else if (!enabled) begin
         start_clear_reg <= 1'b0;
         bus_busy_reg    <= 1'b0;
         clock_level_reg <= 1'b0;
         data_level_reg  <= 1'b0;
      end else begin
         clock_level_reg <= scl_s;
         data_level_reg  <= sda_s;
         if (start_ev || en_start) begin
            bus_busy_reg <= 1'b1;
         end else if (stop_ev) begin
            bus_busy_reg <= 1'b0;
         end
         if (ctrl_wr && wdata_i[`BIT_START_TRIGGER] && bus_busy_reg) begin
            start_clear_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // Line drivers, open drain
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         scl_hold_reg      <= 1'b0;
         sda_drive_low_reg <= 1'b0;
      end else if (!enabled || leave_go || state_reg != ST_ACTIVE) begin
         scl_hold_reg      <= 1'b0;
         sda_drive_low_reg <= 1'b0;
      end else begin
         scl_hold_reg <= wait_reg & ~release_go;
         if (release_go && ninth_wait && status_reg[`BIT_TRANSMIT_DIR]) begin
            sda_drive_low_reg <= 1'b0;
         end
      end
   end

   assign scl_o    = 1'b0;
   assign scl_oe_o = scl_hold_reg;
   assign sda_o    = 1'b0;
   assign sda_oe_o = sda_drive_low_reg;

   // ==========================================
   // Line event capture, cleared by a write to the line event register
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         event_reg <= 2'h0;
      end else begin
         event_reg[1] <= start_ev | en_start | (event_reg[1] & ~wr_hit(addr_i, `ADDR_LINE_EVENT, wr_i));
         event_reg[0] <= stop_ev | (event_reg[0] & ~wr_hit(addr_i, `ADDR_LINE_EVENT, wr_i));
      end
   end

   // ==========================================
   // Read data, one cycle after the strobe
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o    <= `RST_BYTE;
      end else begin
         if (rd_i) begin
            case (addr_i)
               `ADDR_BUS_CONTROL:  rdata_o <= ctrl_reg;
               `ADDR_BUS_STATUS:   rdata_o <= status_reg;
               `ADDR_BUS_FLAG:     rdata_o <= {start_clear_reg, bus_busy_reg, 6'h00};
               `ADDR_CLOCK_SELECT: rdata_o <= {2'h0, clock_level_reg, data_level_reg, 4'h0};
               `ADDR_LINE_EVENT:   rdata_o <= {6'h00, event_reg};
               default:            rdata_o <= `RST_BYTE;
            endcase
         end else begin
            rdata_o <= `RST_BYTE;
         end
      end
   end

   // ==========================================
   // State outputs
   assign standby_o = state_reg[2];
   assign waiting_o = wait_reg;
endmodule // i2c_control_register_logic

/* File: testbench/i2c_ctrl_properties.sv */
// Concurrent checks on the ports of the I2C control register logic
`timescale 1ns/1ps
module i2c_ctrl_properties (
   // Clock and reset
   input wire       mclk_i,
   input wire       rst_i,
   // Register port
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire       wr_i,
   input wire       rd_i,
   input wire [7:0] rdata_o,
   // Lines
   input wire       sda_i,
   input wire       scl_oe_o,
   input wire       sda_oe_o,
   // Engine inputs and block state
   input wire       addr_match_i,
   input wire       ext_code_i,
   input wire       standby_o,
   input wire       waiting_o
);
   // ==========================================
   // Clocking and decoded writes
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   wire ctl_wr   = wr_i && addr_i == 4'h0;
   wire leave_wr = ctl_wr && wdata_i[7] && wdata_i[6];

   // ==========================================
   // Checks
   leave_standby_a: assert property (leave_wr |-> ##2 standby_o)
      else $error("standby not entered");
   leave_release_a: assert property (leave_wr |-> ##2 (!scl_oe_o && !sda_oe_o))
      else $error("lines not released on leave");
   off_no_leave_a: assert property (ctl_wr && !wdata_i[7] && !standby_o |-> ##2 !standby_o)
      else $error("leave acted while disabled");
   ctl_readback_a: assert property (ctl_wr && wdata_i[6:5] == 2'b00 ##2 rd_i && addr_i == 4'h0
      |=> (rdata_o & 8'hFC) == ($past(wdata_i, 3) & 8'hFC)) else $error("control readback wrong");
   leave_flags_a: assert property (standby_o && !addr_match_i && !ext_code_i && rd_i && addr_i == 4'h1
      |=> rdata_o[7:3] == 5'h00) else $error("status flags kept in standby");
   off_status_a: assert property (ctl_wr && !wdata_i[7] ##[2:6] rd_i && addr_i == 4'h1
      |=> rdata_o == 8'h00) else $error("status not reset when disabled");
   off_flags_a: assert property (ctl_wr && !wdata_i[7] ##[2:6] rd_i && addr_i == 4'h2
      |=> rdata_o[7:6] == 2'b00) else $error("flag bits not reset when disabled");
   release_wait_a: assert property (waiting_o && ctl_wr && wdata_i[7] && wdata_i[5] |-> ##[1:4] !waiting_o)
      else $error("wait not released");
   wait_clock_a: assert property (waiting_o && $past(waiting_o) |-> scl_oe_o)
      else $error("clock not held during wait");
   standby_hold_a: assert property ((standby_o && !addr_match_i && !ext_code_i && !wr_i && $stable(sda_i)) [*6]
      |=> standby_o) else $error("standby left without cause");
endmodule // i2c_ctrl_properties

bind i2c_control_register_logic i2c_ctrl_properties u_i2c_ctrl_properties (
   .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .sda_i(sda_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
   .addr_match_i(addr_match_i), .ext_code_i(ext_code_i), .standby_o(standby_o), .waiting_o(waiting_o));

/* File: testbench/i2c_bus_peer.sv */
// Behavioural model of the other party on the I2C bus
`timescale 1ns/1ps
module i2c_bus_peer (
   // Open-drain pulls, high pulls the line low
   output reg scl_low_o,
   output reg sda_low_o
);
   // ==========================================
   // Half period of the 160 ns link clock
   localparam real HALF = 80.0;

   // Lines released at start
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // Data falls while clock is high
   task bus_start;
      begin
         #1.3;
         sda_low_o = 1'b1;
         #HALF;
      end
   endtask

   // Data rises while clock is high
   task bus_stop;
      begin
         #1.3;
         sda_low_o = 1'b0;
         #HALF;
      end
   endtask

   // Clock pulses, clock stands still afterwards
   task bus_clocks(input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            scl_low_o = 1'b1;
            #HALF;
            scl_low_o = 1'b0;
            #HALF;
         end
      end
   endtask
endmodule // i2c_bus_peer

/* File: testbench/i2c_control_register_logic_test.sv */
// Self-checking bench for the I2C control register logic
`timescale 1ns/1ps
module i2c_control_register_logic_test;
   // ==========================================
   // Signals
   reg        mclk_i       = 1'b0;
   reg        rst_i        = 1'b1;
   reg  [3:0] addr_i       = 4'h0;
   reg  [7:0] wdata_i      = 8'h00;
   reg        wr_i         = 1'b0;
   reg        rd_i         = 1'b0;
   reg        addr_match_i = 1'b0;
   reg        ext_code_i   = 1'b0;
   reg        ack_seen_i   = 1'b0;
   reg        tx_dir_set_i = 1'b0;
   reg        master_set_i = 1'b0;
   reg        wait_hold_i  = 1'b0;
   reg  [7:0] rd_val;
   wire [7:0] rdata_o;
   wire       scl_oe_o, sda_oe_o, standby_o, waiting_o, scl_low, sda_low;
   integer    bad_count = 0;
   integer    compares  = 0;
   integer    i;
   // Wired-AND lines with pull-ups
   wire       scl_bus = !(scl_low | scl_oe_o);
   wire       sda_bus = !(sda_low | sda_oe_o);

   // 250 MHz clock
   always #2 mclk_i = ~mclk_i;

   i2c_control_register_logic u_i2c_control_register_logic (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .scl_i(scl_bus), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda_bus), .sda_o(),
      .sda_oe_o(sda_oe_o), .addr_match_i(addr_match_i), .ext_code_i(ext_code_i), .ack_seen_i(ack_seen_i),
      .tx_dir_set_i(tx_dir_set_i), .master_set_i(master_set_i), .wait_hold_i(wait_hold_i),
      .standby_o(standby_o), .waiting_o(waiting_o));

   i2c_bus_peer u_i2c_bus_peer (.scl_low_o(scl_low), .sda_low_o(sda_low));

   // ==========================================
   // Access and check tasks
   task reg_wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge mclk_i);
         addr_i  <= a;
         wdata_i <= d;
         wr_i    <= 1'b1;
         @(posedge mclk_i);
         wr_i    <= 1'b0;
      end
   endtask

   task reg_rd(input [3:0] a);
      begin
         @(posedge mclk_i);
         addr_i <= a;
         rd_i   <= 1'b1;
         @(posedge mclk_i);
         rd_i   <= 1'b0;
         // Data taken at the edge that closes its cycle
         @(posedge mclk_i);
         rd_val = rdata_o;
      end
   endtask

   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task idle(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask

   task finish_test;
      begin
         $display("compares %0d mismatches %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // Watchdog
   initial begin
      #100000;
      bad_count = bad_count + 1;
      finish_test;
   end

   // ==========================================
   // Test sequence
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         reg_rd(i[3:0]);
         chk(rd_val, 8'h00);
      end
      reg_rd(4'hF);
      chk(rd_val, 8'h00);
      reg_wr(4'h0, 8'h9C);
      reg_rd(4'h0);
      chk(rd_val, 8'h9C);
      reg_wr(4'h0, 8'h60);
      reg_rd(4'h0);
      chk(rd_val, 8'h00);
      chk({7'h00, standby_o}, 8'h00);
      $display("test 1 done");
      // Enable with data low, then leave
      u_i2c_bus_peer.bus_start;
      reg_wr(4'h0, 8'h80);
      idle(6);
      reg_rd(4'h1);
      chk(rd_val & 8'h04, 8'h04);
      master_set_i <= 1'b1;
      ack_seen_i   <= 1'b1;
      tx_dir_set_i <= 1'b1;
      idle(1);
      master_set_i <= 1'b0;
      ack_seen_i   <= 1'b0;
      tx_dir_set_i <= 1'b0;
      reg_wr(4'h0, 8'hC3);
      idle(3);
      chk({6'h00, standby_o, scl_oe_o | sda_oe_o}, 8'h02);
      reg_rd(4'h0);
      chk(rd_val, 8'h80);
      reg_rd(4'h1);
      chk(rd_val & 8'hFC, 8'h00);
      $display("test 2 done");
      // Standby persists, then ends by stop, match or extension code
      idle(20);
      chk({7'h00, standby_o}, 8'h01);
      u_i2c_bus_peer.bus_stop;
      idle(6);
      chk({7'h00, standby_o}, 8'h00);
      for (i = 0; i < 2; i = i + 1) begin
         reg_wr(4'h0, 8'hC0);
         idle(3);
         chk({7'h00, standby_o}, 8'h01);
         u_i2c_bus_peer.bus_start;
         idle(4);
         chk({7'h00, standby_o}, 8'h01);
         if (i == 0)
            addr_match_i <= 1'b1;
         else
            ext_code_i <= 1'b1;
         idle(2);
         addr_match_i <= 1'b0;
         ext_code_i   <= 1'b0;
         idle(2);
         chk({7'h00, standby_o}, 8'h00);
         u_i2c_bus_peer.bus_stop;
      end
      $display("test 3 done");
      // Wait at the ninth clock while transmitting
      u_i2c_bus_peer.bus_start;
      idle(1);
      tx_dir_set_i <= 1'b1;
      idle(1);
      tx_dir_set_i <= 1'b0;
      u_i2c_bus_peer.bus_clocks(9);
      idle(1);
      wait_hold_i <= 1'b1;
      u_i2c_bus_peer.bus_clocks(1);
      idle(2);
      chk({6'h00, waiting_o, scl_oe_o}, 8'h03);
      reg_rd(4'h1);
      chk(rd_val & 8'h10, 8'h10);
      reg_wr(4'h0, 8'hA0);
      idle(4);
      chk({6'h00, waiting_o, sda_oe_o}, 8'h00);
      reg_rd(4'h0);
      chk(rd_val, 8'h80);
      reg_rd(4'h1);
      chk(rd_val & 8'h10, 8'h00);
      wait_hold_i <= 1'b0;
      $display("test 4 done");
      // Disable resets status and flags
      reg_rd(4'h2);
      chk(rd_val & 8'hC0, 8'hC0);
      reg_rd(4'h3);
      chk(rd_val & 8'h30, 8'h20);
      reg_rd(4'h4);
      chk(rd_val, 8'h03);
      reg_wr(4'h4, 8'h00);
      reg_rd(4'h4);
      chk(rd_val, 8'h00);
      reg_wr(4'h0, 8'h00);
      reg_rd(4'h2);
      chk(rd_val & 8'hC0, 8'h00);
      reg_rd(4'h1);
      chk(rd_val, 8'h00);
      reg_rd(4'h3);
      chk(rd_val & 8'h30, 8'h00);
      u_i2c_bus_peer.bus_stop;
      $display("test 5 done");
      // Reset in mid-run clears the control bits
      reg_wr(4'h0, 8'h9C);
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      reg_rd(4'h0);
      chk(rd_val, 8'h00);
      $display("test 6 done");
      finish_test;
   end
endmodule // i2c_control_register_logic_test
